// ---- pkg/uowc_pkg.sv ----
package uowc_pkg;
    // Register byte addresses (printed offsets are byte addresses)
    localparam logic [15:0] USB_SYSTEM_CONTROL_ADDR   = 16'h1c32;
    localparam logic [15:0] RTC_POWER_MANAGEMENT_ADDR = 16'h1930;
    localparam logic [15:0] RTC_REGION_BASE           = 16'h1900;
    localparam int          ADDR_W                    = 16;

    // usb_system_control fields
    localparam int USB_LINE_POLARITY_BIT         = 6;
    localparam int USB_OSC_BIAS_RESISTOR_OFF_BIT = 3;
    localparam int USB_OSC_OFF_BIT               = 2;
    localparam int CPU_ACCESS_WIDTH_LSB          = 0;
    localparam logic [15:0] USB_SYSTEM_CONTROL_MASK  = 16'h004f;
    localparam logic [15:0] USB_SYSTEM_CONTROL_RESET = 16'h004c;

    // rtc_power_management fields
    localparam int WAKE_PIN_OUTPUT_VALUE_BIT = 4;
    localparam int WAKE_PIN_DIRECTION_BIT    = 3;
    localparam int REFERENCE_POWERDOWN_BIT   = 2;
    localparam int REGULATOR_POWERDOWN_BIT   = 1;
    localparam int RTC_CLOCK_OUT_ENABLE_BIT  = 0;
    localparam logic [15:0] RTC_POWER_MANAGEMENT_MASK  = 16'h001f;
    localparam logic [15:0] RTC_POWER_MANAGEMENT_RESET = 16'h0010;

    // Access width encodings
    typedef enum logic [1:0] {
        UOWC_WIDTH_WORD     = 2'h0,
        UOWC_WIDTH_HIGH     = 2'h1,
        UOWC_WIDTH_LOW      = 2'h2,
        UOWC_WIDTH_RESERVED = 2'h3
    } uowc_width_t;

    localparam logic [1:0] AXI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
endpackage

// ---- hw/uowc_masked_reg.sv ----
`timescale 1ns/1ps
// Write-masked 16-bit register; reserved bits stay zero
module uowc_masked_reg #(
    parameter logic [15:0] MASK  = 16'hffff,
    parameter logic [15:0] RESET = 16'h0000
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        we,
    input  wire logic [3:0]  strb,
    input  wire logic [15:0] wdata,
    output logic      [15:0] value
);
    typedef struct packed {
        logic [15:0] r;
    } uowc_mreg_t;

    uowc_mreg_t s_q;
    uowc_mreg_t s_d;
    logic [15:0] lane;

    assign lane = {{8{strb[1]}}, {8{strb[0]}}};

    always_comb begin
        s_d = s_q;
        if (we) begin
            s_d.r = ((s_q.r & ~lane) | (wdata & lane)) & MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{r: RESET & MASK};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign value = s_q.r;
endmodule

// ---- hw/uowc_usb_pads.sv ----
`timescale 1ns/1ps
// USB line polarity swap and oscillator gating
module uowc_usb_pads (
    input  wire logic line_polarity,
    input  wire logic osc_off,
    input  wire logic core_dp,
    input  wire logic core_dm,
    input  wire logic osc_clk_raw,
    output logic      line_dp,
    output logic      line_dm,
    output logic      osc_clk_gated,
    output logic      crystal_oe
);
    assign line_dp       = line_polarity ? core_dp : core_dm;
    assign line_dm       = line_polarity ? core_dm : core_dp;
    assign osc_clk_gated = osc_clk_raw & ~osc_off;
    assign crystal_oe    = ~osc_off;
endmodule

// ---- hw/uowc_regs.sv ----
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Functional notes
// - polarity bit 1 keeps USB lines normal
// - polarity bit 6 at 0 swaps lines
// - bit 3 set disables oscillator bias resistor
// - bit 2 set stops oscillator, tristates crystal
// - bits 1-0 select CPU access width
// - no dynamic RTC clock gating
// - RTC registers inaccessible when oscillator absent
// - RTC power register at 1930h, upper reserved
// - wake output bit 4, 0 drives low
// - wake pin output active low, input high
module uowc_regs (
    input  wire logic                      REF_CLK,
    input  wire logic                      RST,
    input  wire logic                      CE,
    input  wire logic                      RTC_OSC_PRESENT,
    // AXI4-Lite slave
    input  wire logic [uowc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                      S_AXI_AWVALID,
    output logic                           S_AXI_AWREADY,
    input  wire logic [31:0]               S_AXI_WDATA,
    input  wire logic [3:0]                S_AXI_WSTRB,
    input  wire logic                      S_AXI_WVALID,
    output logic                           S_AXI_WREADY,
    output logic [1:0]                     S_AXI_BRESP,
    output logic                           S_AXI_BVALID,
    input  wire logic                      S_AXI_BREADY,
    input  wire logic [uowc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                      S_AXI_ARVALID,
    output logic                           S_AXI_ARREADY,
    output logic [31:0]                    S_AXI_RDATA,
    output logic [1:0]                     S_AXI_RRESP,
    output logic                           S_AXI_RVALID,
    input  wire logic                      S_AXI_RREADY,
    // USB side
    input  wire logic                      CORE_DP,
    input  wire logic                      CORE_DM,
    input  wire logic                      USB_OSC_CLK_RAW,
    output logic                           USB_LINE_DP,
    output logic                           USB_LINE_DM,
    output logic                           USB_OSC_CLK,
    output logic                           USB_CRYSTAL_OUTPUT_PIN_OE,
    output logic                           USB_OSC_BIAS_RESISTOR_OFF,
    output logic                           USB_OSC_OFF,
    output logic [1:0]                     CPU_ACCESS_WIDTH_SELECT,
    // Wake pin, open drain
    input  wire logic                      WAKE_PIN_I,
    output logic                           WAKE_PIN_O,
    output logic                           WAKE_PIN_OE,
    output logic                           WAKE_IN_ACTIVE,
    output logic                           REFERENCE_POWERDOWN,
    output logic                           REGULATOR_POWERDOWN,
    output logic                           RTC_CLOCK_OUT_ENABLE
);
    import uowc_pkg::*;

    typedef struct packed {
        // Write beats, held until the response is taken
        logic                aw_held;
        logic [ADDR_W-1:0]   awaddr;
        logic                w_held;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        // Read response
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        // Output copies, one cycle behind the registers
        logic                dp;
        logic                dm;
        logic                crystal_oe;
        logic                bias_off;
        logic                osc_off;
        logic [1:0]          width;
        logic                wake_o;
        logic                wake_oe;
        logic                wake_in;
        logic                ref_pd;
        logic                reg_pd;
        logic                clk_out_en;
    } uowc_state_t;

    uowc_state_t s_q;
    uowc_state_t s_d;

    logic [15:0] usb_ctl;
    logic [15:0] rtc_pm;
    logic        do_write;
    logic        we_usb;
    logic        we_rtc;
    logic        p_dp;
    logic        p_dm;
    logic        p_clk;
    logic        p_oe;

    // Channel events
    logic        aw_take;
    logic        w_take;
    logic        b_done;
    logic        ar_take;
    logic        r_done;

    // Decoded targets
    logic        aw_usb;
    logic        aw_rtc;
    logic        ar_usb;
    logic        ar_rtc;
    logic        rtc_open;
    logic        aw_ok;
    logic        ar_ok;

    logic        bus_live;

    // Bus moves only while enabled; a ready shown while frozen would
    // let the master hand over a beat that nobody stores
    assign bus_live = CE;
    assign aw_take  = S_AXI_AWVALID && !s_q.aw_held;
    assign w_take   = S_AXI_WVALID && !s_q.w_held;
    assign b_done   = s_q.bvalid && S_AXI_BREADY;
    assign ar_take  = S_AXI_ARVALID && !s_q.rvalid;
    assign r_done   = s_q.rvalid && S_AXI_RREADY;

    // Address decode, shared by commit and response
    assign aw_usb   = s_q.awaddr == USB_SYSTEM_CONTROL_ADDR;
    assign aw_rtc   = s_q.awaddr == RTC_POWER_MANAGEMENT_ADDR;
    assign ar_usb   = S_AXI_ARADDR == USB_SYSTEM_CONTROL_ADDR;
    assign ar_rtc   = S_AXI_ARADDR == RTC_POWER_MANAGEMENT_ADDR;
    // RTC page stays locked while its oscillator is absent
    assign rtc_open = RTC_OSC_PRESENT;
    assign aw_ok    = aw_usb || (aw_rtc && rtc_open);
    assign ar_ok    = ar_usb || (ar_rtc && rtc_open);

    // Write commits once address and data are both held
    assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign we_usb   = do_write && aw_usb;
    assign we_rtc   = do_write && aw_rtc && rtc_open;

    // Both registers share the held strobes and data
    uowc_masked_reg #(
        .MASK  (USB_SYSTEM_CONTROL_MASK),
        .RESET (USB_SYSTEM_CONTROL_RESET)
    ) u_usb_ctl (
        .clk   (REF_CLK),
        .rst   (RST),
        .ce    (CE),
        .we    (we_usb),
        .strb  (s_q.wstrb),
        .wdata (s_q.wdata[15:0]),
        .value (usb_ctl)
    );

    uowc_masked_reg #(
        .MASK  (RTC_POWER_MANAGEMENT_MASK),
        .RESET (RTC_POWER_MANAGEMENT_RESET)
    ) u_rtc_pm (
        .clk   (REF_CLK),
        .rst   (RST),
        .ce    (CE),
        .we    (we_rtc),
        .strb  (s_q.wstrb),
        .wdata (s_q.wdata[15:0]),
        .value (rtc_pm)
    );

    // Pad logic is combinational; the copies below add the flop
    uowc_usb_pads u_pads (
        .line_polarity (usb_ctl[USB_LINE_POLARITY_BIT]),
        .osc_off       (usb_ctl[USB_OSC_OFF_BIT]),
        .core_dp       (CORE_DP),
        .core_dm       (CORE_DM),
        .osc_clk_raw   (USB_OSC_CLK_RAW),
        .line_dp       (p_dp),
        .line_dm       (p_dm),
        .osc_clk_gated (p_clk),
        .crystal_oe    (p_oe)
    );

    // RTC domain is never gated here; it has no clock enable of its own.
    // Turning it off means leaving its oscillator out, which shows up
    // here only as RTC_OSC_PRESENT held low

    always_comb begin
        s_d = s_q;

        // Write channels
        if (aw_take) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = S_AXI_AWADDR;
        end
        if (w_take) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = S_AXI_WDATA;
            s_d.wstrb  = S_AXI_WSTRB;
        end
        if (do_write) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = aw_ok ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
        end
        // Response frees both beats so the next write can start
        if (b_done) begin
            s_d.bvalid  = 1'b0;
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
        end

        // Read channel; sees the register before any write at this edge
        if (ar_take) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = 32'h0000_0000;
            s_d.rresp  = AXI_RESP_OKAY;
            if (ar_usb) begin
                s_d.rdata = {16'h0000, usb_ctl};
            end else if (ar_rtc && rtc_open) begin
                s_d.rdata = {16'h0000, rtc_pm};
            end else begin
                s_d.rresp = AXI_RESP_SLVERR;
            end
        end else if (r_done) begin
            s_d.rvalid = 1'b0;
        end

        // Registered pad and control outputs
        s_d.dp         = p_dp;
        s_d.dm         = p_dm;
        s_d.crystal_oe = p_oe;
        s_d.bias_off   = usb_ctl[USB_OSC_BIAS_RESISTOR_OFF_BIT];
        s_d.osc_off    = usb_ctl[USB_OSC_OFF_BIT];
        s_d.width      = usb_ctl[CPU_ACCESS_WIDTH_LSB +: 2];

        // Open drain: only ever pulls low, output mode only
        s_d.wake_o  = 1'b0;
        s_d.wake_oe = rtc_pm[WAKE_PIN_DIRECTION_BIT]
                      && !rtc_pm[WAKE_PIN_OUTPUT_VALUE_BIT];
        s_d.wake_in = !rtc_pm[WAKE_PIN_DIRECTION_BIT]
                      && WAKE_PIN_I;
        s_d.ref_pd     = rtc_pm[REFERENCE_POWERDOWN_BIT];
        s_d.reg_pd     = rtc_pm[REGULATOR_POWERDOWN_BIT];
        s_d.clk_out_en = rtc_pm[RTC_CLOCK_OUT_ENABLE_BIT];
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            // Every field named so its reset level is plain to see
            s_q.aw_held    <= 1'b0;
            s_q.awaddr     <= '0;
            s_q.w_held     <= 1'b0;
            s_q.wdata      <= 32'h0000_0000;
            s_q.wstrb      <= 4'h0;
            s_q.bvalid     <= 1'b0;
            s_q.bresp      <= AXI_RESP_OKAY;
            s_q.rvalid     <= 1'b0;
            s_q.rdata      <= 32'h0000_0000;
            s_q.rresp      <= AXI_RESP_OKAY;
            s_q.dp         <= 1'b0;
            s_q.dm         <= 1'b0;
            s_q.crystal_oe <= 1'b0;
            s_q.bias_off   <= 1'b1;
            s_q.osc_off    <= 1'b1;
            s_q.width      <= 2'h0;
            s_q.wake_o     <= 1'b0;
            s_q.wake_oe    <= 1'b0;
            s_q.wake_in    <= 1'b0;
            s_q.ref_pd     <= 1'b0;
            s_q.reg_pd     <= 1'b0;
            s_q.clk_out_en <= 1'b0;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // Handshake outputs pause with the enable
    assign S_AXI_AWREADY = bus_live && !s_q.aw_held;
    assign S_AXI_WREADY  = bus_live && !s_q.w_held;
    assign S_AXI_BVALID  = bus_live && s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = bus_live && !s_q.rvalid;
    assign S_AXI_RVALID  = bus_live && s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;

    assign USB_LINE_DP               = s_q.dp;
    assign USB_LINE_DM               = s_q.dm;
    // Gated clock stays combinational; a flop would divide it
    assign USB_OSC_CLK               = p_clk;
    assign USB_CRYSTAL_OUTPUT_PIN_OE = s_q.crystal_oe;
    assign USB_OSC_BIAS_RESISTOR_OFF = s_q.bias_off;
    assign USB_OSC_OFF               = s_q.osc_off;
    assign CPU_ACCESS_WIDTH_SELECT   = s_q.width;
    assign WAKE_PIN_O                = s_q.wake_o;
    assign WAKE_PIN_OE               = s_q.wake_oe;
    assign WAKE_IN_ACTIVE            = s_q.wake_in;
    assign REFERENCE_POWERDOWN       = s_q.ref_pd;
    assign REGULATOR_POWERDOWN       = s_q.reg_pd;
    assign RTC_CLOCK_OUT_ENABLE      = s_q.clk_out_en;
endmodule

// ---- bench/uowc_regs_props.sv ----
`timescale 1ns/1ps
module uowc_regs_props (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        CORE_DP,
    input wire logic        CORE_DM,
    input wire logic        USB_LINE_DP,
    input wire logic        USB_LINE_DM,
    input wire logic        USB_OSC_OFF,
    input wire logic        USB_CRYSTAL_OUTPUT_PIN_OE,
    input wire logic        WAKE_PIN_I,
    input wire logic        WAKE_PIN_O,
    input wire logic        WAKE_PIN_OE,
    input wire logic        WAKE_IN_ACTIVE,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP
);
    import uowc_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    line_pair_a: assert property (
        !$past(RST) |-> (USB_LINE_DP ^ USB_LINE_DM) == ($past(CORE_DP) ^
        $past(CORE_DM))) else $error("usb line pair broken");
    crystal_oe_a: assert property (
        USB_CRYSTAL_OUTPUT_PIN_OE == !USB_OSC_OFF) else $error("xtal oe");
    wake_od_a: assert property (!WAKE_PIN_O)
        else $error("wake pin driven high");
    wake_dir_a: assert property (
        WAKE_IN_ACTIVE |-> !WAKE_PIN_OE && $past(WAKE_PIN_I))
        else $error("wake input while driving");
    wr_resp_a: assert property (
        wr_taken |=> !S_AXI_AWREADY ##1 S_AXI_BVALID) else $error("b late");
    b_hold_a: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("b drop");
    rd_resp_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("r late");
    r_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("r data moved");
    rd_zero_a: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0 && !S_AXI_ARREADY &&
        (S_AXI_RRESP != AXI_RESP_SLVERR || S_AXI_RDATA == 32'h0))
        else $error("read data not zero");
endmodule
bind uowc_regs uowc_regs_props u_props (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import uowc_pkg::*;
    logic        REF_CLK, RST, CE, RTC_OSC_PRESENT, CORE_DP, CORE_DM;
    logic [15:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, CPU_ACCESS_WIDTH_SELECT;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic        S_AXI_RVALID, S_AXI_RREADY, USB_OSC_CLK_RAW, USB_OSC_CLK;
    logic        USB_LINE_DP, USB_LINE_DM, USB_CRYSTAL_OUTPUT_PIN_OE;
    logic        USB_OSC_BIAS_RESISTOR_OFF, USB_OSC_OFF, WAKE_PIN_I;
    logic        WAKE_PIN_O, WAKE_PIN_OE, WAKE_IN_ACTIVE, REFERENCE_POWERDOWN;
    logic        REGULATOR_POWERDOWN, RTC_CLOCK_OUT_ENABLE;
    logic [13:0] outs;
    int          err_count = 0;
    int          num_checks = 0;
    localparam logic [15:0] USB = USB_SYSTEM_CONTROL_ADDR;
    localparam logic [15:0] RTC = RTC_POWER_MANAGEMENT_ADDR;
    localparam logic [1:0]  OK = AXI_RESP_OKAY;
    localparam logic [1:0]  ERR = AXI_RESP_SLVERR;
    assign outs = {USB_OSC_CLK, USB_LINE_DP, USB_LINE_DM,
        USB_CRYSTAL_OUTPUT_PIN_OE, USB_OSC_BIAS_RESISTOR_OFF, USB_OSC_OFF,
        CPU_ACCESS_WIDTH_SELECT, WAKE_PIN_O, WAKE_PIN_OE, WAKE_IN_ACTIVE,
        REFERENCE_POWERDOWN, REGULATOR_POWERDOWN, RTC_CLOCK_OUT_ENABLE};
    uowc_regs dut (.*);
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Handshakes sampled at negedge so the release lands on the taking edge
    task automatic bus(input bit wr, input logic [15:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit          at, wt, got;
        logic [31:0] rd;
        logic [1:0]  rr;
        got = 1'b0;
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_ARADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= wr;
        S_AXI_WVALID <= wr;
        S_AXI_BREADY <= wr;
        S_AXI_ARVALID <= !wr;
        S_AXI_RREADY <= !wr;
        for (int n = 0; n < 50 && !got; n++) begin
            @(negedge REF_CLK);
            at = (S_AXI_AWVALID && S_AXI_AWREADY) ||
                 (S_AXI_ARVALID && S_AXI_ARREADY);
            wt = S_AXI_WVALID && S_AXI_WREADY;
            got = wr ? S_AXI_BVALID && S_AXI_BREADY
                     : S_AXI_RVALID && S_AXI_RREADY;
            rr = wr ? S_AXI_BRESP : S_AXI_RRESP;
            rd = S_AXI_RDATA;
            @(posedge REF_CLK);
            if (at) begin
                S_AXI_AWVALID <= 1'b0;
                S_AXI_ARVALID <= 1'b0;
            end
            if (wt) begin
                S_AXI_WVALID <= 1'b0;
            end
            if (got) begin
                S_AXI_BREADY <= 1'b0;
                S_AXI_RREADY <= 1'b0;
            end
        end
        if (!got) begin
            err_count++;
            $display("MISMATCH t=%0t bus timeout", $time);
            test_done();
        end else begin
            chk({30'h0, rr}, {30'h0, er});
            if (!wr) begin
                chk(rd, d);
            end
        end
    endtask
    // Derived outputs other than USB_OSC_CLK lag the register by one cycle
    task automatic outchk(input logic [13:0] e);
        repeat (2) @(negedge REF_CLK);
        chk({18'h0, outs}, {18'h0, e});
    endtask
    initial begin
        RST = 1'b1;
        CE = 1'b1;
        RTC_OSC_PRESENT = 1'b1;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
        {S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
        {CORE_DP, CORE_DM, USB_OSC_CLK_RAW, WAKE_PIN_I} = 4'hb;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        outchk(14'h1308);
        bus(1'b0, USB, 32'h4c, 4'h0, OK);
        bus(1'b0, RTC, 32'h10, 4'h0, OK);
        bus(1'b1, USB, 32'hffff, 4'h3, OK);
        bus(1'b0, USB, 32'h4f, 4'h0, OK);
        outchk(14'h13c8);
        bus(1'b1, USB, 32'h0, 4'h3, OK);
        outchk(14'h2c08);
        for (int w = 0; w < 4; w++) begin
            bus(1'b1, USB, 32'h40 | 32'(w), 4'h1, OK);
            outchk(14'h3408 | 14'(w << 6));
        end
        bus(1'b1, USB, 32'hff, 4'h2, OK);
        bus(1'b0, USB, 32'h43, 4'h0, OK);
        bus(1'b1, RTC, 32'hffff, 4'h3, OK);
        bus(1'b0, RTC, 32'h1f, 4'h0, OK);
        outchk(14'h34c7);
        bus(1'b1, RTC, 32'h8, 4'h1, OK);
        outchk(14'h34d0);
        bus(1'b1, RTC, 32'h7, 4'h1, OK);
        outchk(14'h34cf);
        @(posedge REF_CLK);
        WAKE_PIN_I <= 1'b0;
        outchk(14'h34c7);
        bus(1'b0, 16'h1000, 32'h0, 4'h0, ERR);
        bus(1'b1, 16'h1000, 32'h5, 4'h3, ERR);
        RTC_OSC_PRESENT <= 1'b0;
        bus(1'b1, RTC, 32'h0, 4'h3, ERR);
        bus(1'b0, RTC, 32'h0, 4'h0, ERR);
        bus(1'b1, USB, 32'h4c, 4'h3, OK);
        RTC_OSC_PRESENT <= 1'b1;
        bus(1'b0, RTC, 32'h7, 4'h0, OK);
        test_done();
    end
endmodule
